// ### rtl/dpsr_top.sv
`include "dpsr_defs.svh"

// Functional notes
// RULE1: power code 01 cuts third, 10 two fifths
// RULE2: host keeps master clock under 10 MHz; the testbench runs it at 200 MHz
// RULE3: receive on if pin or bit high
// RULE4: control b bit 4 picks stream port
// RULE5: aux control a bit 2 powers converter
// RULE6: aux control b bit 0 resets aux
// RULE7: frames are sixteen bits, data plus address
// RULE8: msb first, data high, address low
// RULE9: write stores data, read-only left alone
// RULE10: read pointer write answers after four cycles
// RULE11: read pointer takes frame bits 11..6
// RULE12: answer frame is data then source address
// RULE13: receive words stream on selected port
// RULE14: I word goes before Q word
// RULE15: sample in upper fifteen bits, flag lsb
// RULE16: flag zero for I, one for Q
// RULE17: soft resets self clear after four cycles
// RULE18: reference stays up when keep-alive set
// RULE19: one I/Q pair per 48 clocks
// RULE20: reserved bits read zero, ignore writes
// RULE21: unassigned addresses drop the write
module dpsr_top #(
  parameter int unsigned RX_START_CYCLES = 96  // link cycles from receive on to first pair
) (
  input  wire logic                    sys_clk,
  input  wire logic                    resetn,
  input  wire logic                    link_clk,
  input  wire logic                    receive_enable,
  input  wire logic                    bb_host_fs,
  input  wire logic                    bb_sdi,
  output wire logic                    bb_fs,
  output wire logic                    bb_serial_out,
  input  wire logic                    aux_host_fs,
  input  wire logic                    aux_sdi,
  output wire logic                    aux_fs,
  output wire logic                    aux_serial_out,
  input  wire dpsr_pkg::dpsr_sample_t  i_sample,
  input  wire dpsr_pkg::dpsr_sample_t  q_sample,
  output logic                         rx_section_on,
  output logic                         rx_cut_third,
  output logic                         rx_cut_two_fifths,
  output logic                         ref_keep_alive,
  output logic                         ref_output_use,
  output logic                         bandgap_reference,
  output logic                         aux_converter_power,
  output dpsr_pkg::dpsr_data_t         aux_converter_word
);
  import dpsr_pkg::*;

  // port index 0 is baseband, 1 is aux
  logic [1:0]  host_fs_a;
  logic [1:0]  sdi_a;
  logic [1:0]  fs_a;
  logic [1:0]  sdo_a;

  // sys domain state
  logic        pin_meta, pin_sync;                // receive pin synchroniser
  logic [1:0]  rxt_meta, rxt_sync, rxt_seen;      // frame-received toggles
  dpsr_data_t  bb_ca, next_bb_ca;                 // baseband control a, modelled bits
  dpsr_data_t  bb_cb, next_bb_cb;                 // baseband control b
  dpsr_data_t  aux_ca, next_aux_ca;               // aux control a
  dpsr_data_t  aux_word, next_aux_word;           // aux converter word
  dpsr_addr_t  rd_ptr [2];                        // read pointers
  dpsr_addr_t  next_rd_ptr [2];
  logic [2:0]  rd_cnt [2];                        // read answer countdowns
  logic [2:0]  next_rd_cnt [2];
  dpsr_frame_t resp_word [2];                     // answer held for the link side
  dpsr_frame_t next_resp_word [2];
  logic [1:0]  resp_tgl, next_resp_tgl;           // answer-ready toggles
  logic [2:0]  a_cnt, next_a_cnt;                 // aux soft reset countdown
  logic [2:0]  b_cnt, next_b_cnt;                 // baseband soft reset countdown
  logic        next_rx_on, next_cut3, next_cut25, next_lp, next_ru, next_bg, next_dac;
  dpsr_data_t  rd_data [2];                       // contents at each read pointer
  logic [1:0]  wr_stb;                            // new frame from each port

  // link domain state
  logic        on_meta, on_sync;                  // receive on, crossed
  logic        sel_meta, sel_sync;                // port select, crossed
  logic [1:0]  resp_meta, resp_sync, resp_seen;
  logic [1:0]  resp_pend, next_resp_pend;         // answer waiting for its port
  logic [1:0]  strm_pend, next_strm_pend;         // stream word waiting
  dpsr_frame_t strm_word [2];
  dpsr_frame_t next_strm_word [2];
  logic [7:0]  start_cnt, next_start_cnt;         // start-up delay
  logic [5:0]  pace, next_pace;                   // pair slot counter
  logic        sel_lat, next_sel_lat;             // port frozen while streaming
  dpsr_sample_t q_hold, next_q_hold;              // Q taken with its I
  logic [1:0]  rxt_l, next_rxt_l;                 // frame-received toggles
  dpsr_frame_t rx_word_l [2];                     // last frame, stable for sys side
  dpsr_frame_t next_rx_word_l [2];

  dpsr_link_if lnk [2] ();
  logic [1:0]  tx_take, rx_vld;  // word taken, frame received
  dpsr_frame_t rx_wd [2];        // frame from each engine

  assign host_fs_a      = {aux_host_fs, bb_host_fs};
  assign sdi_a          = {aux_sdi, bb_sdi};
  assign bb_fs          = fs_a[0];
  assign bb_serial_out  = sdo_a[0];
  assign aux_fs         = fs_a[1];
  assign aux_serial_out = sdo_a[1];

  // per-port engine and transmit choice; stream words outrank answers
  for (genvar p = 0; p < 2; p++)
  begin : g_port
    dpsr_serial_engine u_eng (
      .link_clk   (link_clk),
      .resetn     (resetn),
      .host_fs    (host_fs_a[p]),
      .sdi        (sdi_a[p]),
      .fs         (fs_a[p]),
      .serial_out (sdo_a[p]),
      .bus        (lnk[p].engine)
    );
    assign lnk[p].tx_valid = strm_pend[p] | resp_pend[p];
    // resp_word is held steady from toggle until the next read
    assign lnk[p].tx_word  = strm_pend[p] ? strm_word[p] : resp_word[p];
    assign wr_stb[p]       = rxt_sync[p] ^ rxt_seen[p];
    // plain vectors, since loops may not index interface arrays
    assign tx_take[p]      = lnk[p].tx_valid & lnk[p].tx_ready;
    assign rx_vld[p]       = lnk[p].rx_valid;
    assign rx_wd[p]        = lnk[p].rx_word;
  end

  // read mux; reserved bits and unmapped addresses give zero
  always_comb
  begin
    for (int p = 0; p < 2; p++)
    begin
      case (rd_ptr[p])
        `DPSR_ADDR_RDPTR_AUX: rd_data[p] = {4'h0, rd_ptr[1]};
        `DPSR_ADDR_RDPTR_BB:  rd_data[p] = {4'h0, rd_ptr[0]};
        `DPSR_ADDR_AUX_WORD:  rd_data[p] = aux_word;
        `DPSR_ADDR_AUX_CA:    rd_data[p] = aux_ca;  // RULE20
        `DPSR_ADDR_AUX_CB:    rd_data[p] = {9'h000, a_cnt != 3'h0};
        `DPSR_ADDR_BB_CA:     rd_data[p] = bb_ca | {2'h0, b_cnt != 3'h0, 7'h00};
        `DPSR_ADDR_BB_CB:     rd_data[p] = bb_cb;
        default:              rd_data[p] = `DPSR_ZERO10;
      endcase
    end
  end

  // register writes, read timers, soft resets, block outputs
  always_comb
  begin
    logic [15:0] f;
    logic [9:0]  d;
    f              = `DPSR_ZERO16;
    d              = `DPSR_ZERO10;
    next_bb_ca     = bb_ca;
    next_bb_cb     = bb_cb;
    next_aux_ca    = aux_ca;
    next_aux_word  = aux_word;
    next_resp_tgl  = resp_tgl;
    next_a_cnt     = (a_cnt != 3'h0) ? a_cnt - 3'h1 : a_cnt;  // RULE17
    next_b_cnt     = (b_cnt != 3'h0) ? b_cnt - 3'h1 : b_cnt;  // RULE17
    for (int p = 0; p < 2; p++)
    begin
      next_rd_ptr[p]    = rd_ptr[p];
      next_resp_word[p] = resp_word[p];
      next_rd_cnt[p]    = (rd_cnt[p] != 3'h0) ? rd_cnt[p] - 3'h1 : rd_cnt[p];
      // answer goes out with data then source address
      if (rd_cnt[p] == 3'h1)  // RULE10
      begin
        next_resp_word[p] = {rd_data[p], rd_ptr[p]};  // RULE12
        next_resp_tgl[p]  = ~resp_tgl[p];
      end
    end
    // aux frame applied last
    for (int p = 0; p < 2; p++)
    begin
      if (wr_stb[p])
      begin
        f = rx_word_l[p];
        d = f[`DPSR_DATA_MSB:`DPSR_DATA_LSB];  // RULE8
        case (f[`DPSR_ADDR_MSB:`DPSR_ADDR_LSB])  // RULE9
          `DPSR_ADDR_RDPTR_BB:
          begin
            next_rd_ptr[0] = f[`DPSR_RDPTR_MSB:`DPSR_RDPTR_LSB];  // RULE11
            next_rd_cnt[0] = `DPSR_READ_LAT_CYCLES;  // RULE10
          end
          `DPSR_ADDR_RDPTR_AUX:
          begin
            next_rd_ptr[1] = f[`DPSR_RDPTR_MSB:`DPSR_RDPTR_LSB];  // RULE11
            next_rd_cnt[1] = `DPSR_READ_LAT_CYCLES;  // RULE10
          end
          `DPSR_ADDR_AUX_WORD:
            next_aux_word = d;
          `DPSR_ADDR_AUX_CA:
            next_aux_ca = d & `DPSR_ACA_WMASK;  // RULE20
          `DPSR_ADDR_AUX_CB:
          begin
            if (d[`DPSR_ACB_AUX_SOFT_RESET])  // RULE6
              next_a_cnt = `DPSR_SOFT_RST_CYCLES;
          end
          `DPSR_ADDR_BB_CA:
          begin
            next_bb_ca = d & `DPSR_BCA_WMASK & ~(10'h001 << `DPSR_BCA_BASEBAND_SOFT_RESET);
            if (d[`DPSR_BCA_BASEBAND_SOFT_RESET])
              next_b_cnt = `DPSR_SOFT_RST_CYCLES;  // RULE17
          end
          `DPSR_ADDR_BB_CB:
            next_bb_cb = d & `DPSR_BCB_WMASK;  // RULE20
          default:
            ;  // RULE21
        endcase
      end
    end
    // soft reset spares read pointers; held clear while counting
    if (next_a_cnt != 3'h0)  // RULE6
    begin
      next_aux_ca   = `DPSR_ZERO10;
      next_aux_word = `DPSR_ZERO10;
    end
    if (next_b_cnt != 3'h0)  // RULE17
    begin
      next_bb_ca = `DPSR_ZERO10;
      next_bb_cb = `DPSR_ZERO10;
    end
    next_rx_on = pin_sync | bb_ca[`DPSR_BCA_RECEIVE_ENABLE];  // RULE3
    next_cut3  = ({bb_ca[`DPSR_BCA_PWR_HI], bb_ca[`DPSR_BCA_PWR_LO]} == `DPSR_PWR_MODE1);  // RULE1
    next_cut25 = ({bb_ca[`DPSR_BCA_PWR_HI], bb_ca[`DPSR_BCA_PWR_LO]} == `DPSR_PWR_MODE2);  // RULE1
    next_lp    = bb_cb[`DPSR_BCB_LP];
    next_ru    = bb_cb[`DPSR_BCB_RU];
    next_dac   = aux_ca[`DPSR_ACA_DACON];  // RULE5
    // reference up while anything runs or keep-alive
    next_bg    = next_rx_on | next_dac | next_lp;  // RULE18
  end

  // sys domain registers; pin goes through two flops first
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_meta            <= 1'h0;
      pin_sync            <= 1'h0;
      rxt_meta            <= 2'h0;
      rxt_sync            <= 2'h0;
      rxt_seen            <= 2'h0;
      bb_ca               <= `DPSR_ZERO10;
      bb_cb               <= `DPSR_ZERO10;
      aux_ca              <= `DPSR_ZERO10;
      aux_word            <= `DPSR_ZERO10;
      resp_tgl            <= 2'h0;
      a_cnt               <= 3'h0;
      b_cnt               <= 3'h0;
      rd_ptr              <= '{default: `DPSR_ZERO6};
      rd_cnt              <= '{default: 3'h0};
      resp_word           <= '{default: `DPSR_ZERO16};
      rx_section_on       <= 1'h0;
      rx_cut_third        <= 1'h0;
      rx_cut_two_fifths   <= 1'h0;
      ref_keep_alive      <= 1'h0;
      ref_output_use      <= 1'h0;
      bandgap_reference   <= 1'h0;
      aux_converter_power <= 1'h0;
      aux_converter_word  <= `DPSR_ZERO10;
    end
    else
    begin
      pin_meta            <= receive_enable;
      pin_sync            <= pin_meta;
      rxt_meta            <= rxt_l;
      rxt_sync            <= rxt_meta;
      rxt_seen            <= rxt_sync;
      bb_ca               <= next_bb_ca;
      bb_cb               <= next_bb_cb;
      aux_ca              <= next_aux_ca;
      aux_word            <= next_aux_word;
      resp_tgl            <= next_resp_tgl;
      a_cnt               <= next_a_cnt;
      b_cnt               <= next_b_cnt;
      rd_ptr              <= next_rd_ptr;
      rd_cnt              <= next_rd_cnt;
      resp_word           <= next_resp_word;
      rx_section_on       <= next_rx_on;
      rx_cut_third        <= next_cut3;
      rx_cut_two_fifths   <= next_cut25;
      ref_keep_alive      <= next_lp;
      ref_output_use      <= next_ru;
      bandgap_reference   <= next_bg;
      aux_converter_power <= next_dac;
      aux_converter_word  <= aux_word;
    end
  end

  // link side: stream pacing, answers, frame capture
  always_comb
  begin
    next_start_cnt = start_cnt;
    next_pace      = pace;
    next_sel_lat   = sel_lat;
    next_q_hold    = q_hold;
    next_rxt_l     = rxt_l;
    next_resp_pend = resp_pend;
    next_strm_pend = strm_pend;
    for (int p = 0; p < 2; p++)
    begin
      next_strm_word[p] = strm_word[p];
      next_rx_word_l[p] = rx_word_l[p];
      // a taken word clears its source, stream first
      if (tx_take[p])
      begin
        if (strm_pend[p])
          next_strm_pend[p] = 1'h0;
        else
          next_resp_pend[p] = 1'h0;
      end
      // set after clear: set wins
      if (resp_sync[p] ^ resp_seen[p])
        next_resp_pend[p] = 1'h1;
      if (rx_vld[p])
      begin
        next_rx_word_l[p] = rx_wd[p];
        next_rxt_l[p]     = ~rxt_l[p];
      end
    end
    if (!on_sync)
    begin
      // stream stops; select may change only now
      next_start_cnt = 8'h00;
      next_pace      = 6'h00;
      next_sel_lat   = sel_sync;  // RULE4
      next_strm_pend = 2'h0;
    end
    else if (start_cnt != RX_START_CYCLES[7:0])
      next_start_cnt = start_cnt + 8'h01;
    else
    begin
      next_pace = (pace == `DPSR_PAIR_CYCLES - 6'h01) ? 6'h00 : pace + 6'h01;  // RULE19
      if (pace == 6'h00)  // RULE13
      begin
        next_strm_pend[sel_lat] = 1'h1;
        next_strm_word[sel_lat] = {i_sample, `DPSR_FLAG_I};  // RULE14 RULE15 RULE16
        next_q_hold             = q_sample;
      end
      else if (pace == `DPSR_Q_SLOT)
      begin
        next_strm_pend[sel_lat] = 1'h1;
        next_strm_word[sel_lat] = {q_hold, `DPSR_FLAG_Q};  // RULE14 RULE16
      end
    end
  end

  // link domain registers; levels and toggles cross by two flops
  always_ff @(posedge link_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      on_meta   <= 1'h0;
      on_sync   <= 1'h0;
      sel_meta  <= 1'h0;
      sel_sync  <= 1'h0;
      resp_meta <= 2'h0;
      resp_sync <= 2'h0;
      resp_seen <= 2'h0;
      resp_pend <= 2'h0;
      strm_pend <= 2'h0;
      strm_word <= '{default: `DPSR_ZERO16};
      start_cnt <= 8'h00;
      pace      <= 6'h00;
      sel_lat   <= 1'h0;
      q_hold    <= 15'h0000;
      rxt_l     <= 2'h0;
      rx_word_l <= '{default: `DPSR_ZERO16};
    end
    else
    begin
      on_meta   <= rx_section_on;
      on_sync   <= on_meta;
      sel_meta  <= bb_cb[`DPSR_BCB_PSEL];
      sel_sync  <= sel_meta;
      resp_meta <= resp_tgl;
      resp_sync <= resp_meta;
      resp_seen <= resp_sync;
      resp_pend <= next_resp_pend;
      strm_pend <= next_strm_pend;
      strm_word <= next_strm_word;
      start_cnt <= next_start_cnt;
      pace      <= next_pace;
      sel_lat   <= next_sel_lat;
      q_hold    <= next_q_hold;
      rxt_l     <= next_rxt_l;
      rx_word_l <= next_rx_word_l;
    end
  end
endmodule // dpsr_top

// ### rtl/dpsr_defs.svh
`ifndef DPSR_DEFS_SVH
`define DPSR_DEFS_SVH

// register addresses
`define DPSR_ADDR_RDPTR_AUX 6'h09
`define DPSR_ADDR_RDPTR_BB  6'h0A
`define DPSR_ADDR_AUX_WORD  6'h0C
`define DPSR_ADDR_AUX_CA    6'h12
`define DPSR_ADDR_AUX_CB    6'h13
`define DPSR_ADDR_BB_CA     6'h14
`define DPSR_ADDR_BB_CB     6'h15

// frame field positions
`define DPSR_DATA_MSB  15
`define DPSR_DATA_LSB  6
`define DPSR_ADDR_MSB  5
`define DPSR_ADDR_LSB  0
`define DPSR_RDPTR_MSB 11
`define DPSR_RDPTR_LSB 6

// baseband control a bits
`define DPSR_BCA_PWR_LO 3
`define DPSR_BCA_PWR_HI 4
`define DPSR_BCA_RECEIVE_ENABLE   6
`define DPSR_BCA_BASEBAND_SOFT_RESET 7
// baseband control b bits
`define DPSR_BCB_RU   2
`define DPSR_BCB_LP   3
`define DPSR_BCB_PSEL 4
// aux control bits
`define DPSR_ACA_DACON  2
`define DPSR_ACB_AUX_SOFT_RESET 0

// writable masks, rest reserved
`define DPSR_BCA_WMASK 10'h0D8
`define DPSR_BCB_WMASK 10'h01C
`define DPSR_ACA_WMASK 10'h004

// reset values
`define DPSR_ZERO10 10'h000
`define DPSR_ZERO6  6'h00
`define DPSR_ZERO16 16'h0000

// power mode codes {hi, lo}
`define DPSR_PWR_MODE1 2'h1
`define DPSR_PWR_MODE2 2'h2

// timing, master clock cycles
`define DPSR_SOFT_RST_CYCLES 3'h4
`define DPSR_READ_LAT_CYCLES 3'h4
// timing, link clock cycles
`define DPSR_PAIR_CYCLES 6'h30
`define DPSR_Q_SLOT      6'h18
`define DPSR_FRAME_LAST  4'hF

// receive word flag bit
`define DPSR_FLAG_I 1'h0
`define DPSR_FLAG_Q 1'h1

`endif

// ### rtl/dpsr_pkg.sv
package dpsr_pkg;
  typedef logic [15:0] dpsr_frame_t;   // one serial word
  typedef logic [9:0]  dpsr_data_t;    // register data field
  typedef logic [5:0]  dpsr_addr_t;    // register address field
  typedef logic [14:0] dpsr_sample_t;  // two's complement receive sample
  typedef enum logic {
    dpsr_tx_idle,
    dpsr_tx_shift
  } dpsr_tx_state_t;
endpackage

// ### rtl/dpsr_link_if.sv
// word handshake between a port engine and the link-side control
interface dpsr_link_if;
  logic               tx_valid;  // word waiting to go out
  dpsr_pkg::dpsr_frame_t tx_word;
  logic               tx_ready;  // engine idle, takes the word
  logic               rx_valid;  // one-cycle pulse, frame received
  dpsr_pkg::dpsr_frame_t rx_word;
  modport engine (input tx_valid, input tx_word, output tx_ready,
                  output rx_valid, output rx_word);
  modport ctrl (output tx_valid, output tx_word, input tx_ready,
                input rx_valid, input rx_word);
endinterface

// ### rtl/dpsr_serial_engine.sv
`include "dpsr_defs.svh"

// one serial port: frame sync and bit 15 share the first bit cycle
module dpsr_serial_engine (
  input  wire logic   link_clk,
  input  wire logic   resetn,
  input  wire logic   host_fs,
  input  wire logic   sdi,
  output logic        fs,
  output logic        serial_out,
  dpsr_link_if.engine bus
);
  import dpsr_pkg::*;

  dpsr_tx_state_t tx_state, next_tx_state;  // transmit shifter state
  dpsr_frame_t    tx_sh, next_tx_sh;        // remaining bits
  logic [3:0]     tx_cnt, next_tx_cnt;      // bits still to send
  logic           next_fs, next_serial_out;
  logic           rx_busy, next_rx_busy;    // inside an incoming frame
  dpsr_frame_t    rx_sh, next_rx_sh;
  logic [3:0]     rx_cnt, next_rx_cnt;
  logic           rx_valid, next_rx_valid;
  dpsr_frame_t    rx_word, next_rx_word;

  assign bus.tx_ready = (tx_state == dpsr_tx_idle);
  assign bus.rx_valid = rx_valid;
  assign bus.rx_word  = rx_word;

  // next values for both shifters
  always_comb
  begin
    next_tx_state   = tx_state;
    next_tx_sh      = tx_sh;
    next_tx_cnt     = tx_cnt;
    next_fs         = 1'h0;
    next_serial_out = 1'h0;
    next_rx_busy    = rx_busy;
    next_rx_sh      = rx_sh;
    next_rx_cnt     = rx_cnt;
    next_rx_valid   = 1'h0;
    next_rx_word    = rx_word;
    case (tx_state)
      dpsr_tx_idle:
      begin
        // msb first, sync marks the first bit
        if (bus.tx_valid)  // RULE8
        begin
          next_fs         = 1'h1;
          next_serial_out = bus.tx_word[15];
          next_tx_sh      = {bus.tx_word[14:0], 1'h0};
          next_tx_cnt     = `DPSR_FRAME_LAST;
          next_tx_state   = dpsr_tx_shift;
        end
      end
      dpsr_tx_shift:
      begin
        next_serial_out = tx_sh[15];
        next_tx_sh      = {tx_sh[14:0], 1'h0};
        next_tx_cnt     = tx_cnt - 4'h1;
        // last of sixteen bits loaded
        if (tx_cnt == 4'h1)  // RULE7
          next_tx_state = dpsr_tx_idle;
      end
      default:
        next_tx_state = dpsr_tx_idle;
    endcase
    // incoming frame, bit 15 sampled with the sync
    if (!rx_busy)
    begin
      if (host_fs)
      begin
        next_rx_busy = 1'h1;
        next_rx_sh   = {15'h0000, sdi};
        next_rx_cnt  = `DPSR_FRAME_LAST;
      end
    end
    else
    begin
      next_rx_sh  = {rx_sh[14:0], sdi};
      next_rx_cnt = rx_cnt - 4'h1;
      if (rx_cnt == 4'h1)  // RULE7
      begin
        next_rx_busy  = 1'h0;
        next_rx_valid = 1'h1;
        next_rx_word  = {rx_sh[14:0], sdi};
      end
    end
  end

  // register only
  always_ff @(posedge link_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_state   <= dpsr_tx_idle;
      tx_sh      <= `DPSR_ZERO16;
      tx_cnt     <= 4'h0;
      fs         <= 1'h0;
      serial_out <= 1'h0;
      rx_busy    <= 1'h0;
      rx_sh      <= `DPSR_ZERO16;
      rx_cnt     <= 4'h0;
      rx_valid   <= 1'h0;
      rx_word    <= `DPSR_ZERO16;
    end
    else
    begin
      tx_state   <= next_tx_state;
      tx_sh      <= next_tx_sh;
      tx_cnt     <= next_tx_cnt;
      fs         <= next_fs;
      serial_out <= next_serial_out;
      rx_busy    <= next_rx_busy;
      rx_sh      <= next_rx_sh;
      rx_cnt     <= next_rx_cnt;
      rx_valid   <= next_rx_valid;
      rx_word    <= next_rx_word;
    end
  end
endmodule // dpsr_serial_engine

// ### tb/dpsr_top_checker.sv
// top ports, both clock domains
module dpsr_top_checker (
  input wire logic                 sys_clk,
  input wire logic                 resetn,
  input wire logic                 link_clk,
  input wire logic                 receive_enable,
  input wire logic                 bb_fs,
  input wire logic                 aux_fs,
  input wire logic                 rx_section_on,
  input wire logic                 rx_cut_third,
  input wire logic                 rx_cut_two_fifths,
  input wire logic                 ref_keep_alive,
  input wire logic                 bandgap_reference,
  input wire logic                 aux_converter_power,
  input wire dpsr_pkg::dpsr_data_t aux_converter_word
);
  timeunit 1ns;
  timeprecision 100ps;
  // never both cuts
  property p_cut; @(posedge sys_clk) disable iff (!resetn)
    !(rx_cut_third && rx_cut_two_fifths); endproperty
  a_cut: assert property (p_cut) else $error("both power cuts set");
  // two sync flops plus one register
  property p_pin_on; @(posedge sys_clk) disable iff (!resetn)
    receive_enable [*5] |-> rx_section_on; endproperty
  a_pin_on: assert property (p_pin_on) else $error("receive pin ignored");
  // drop needs pin low 3 samples back
  property p_off; @(posedge sys_clk) disable iff (!resetn)
    $fell(rx_section_on) |-> !$past(receive_enable, 3); endproperty
  a_off: assert property (p_off) else $error("receive dropped with pin high");
  property p_bg_on; @(posedge sys_clk) disable iff (!resetn)
    (rx_section_on || aux_converter_power || ref_keep_alive) [*3] |-> bandgap_reference;
  endproperty
  a_bg_on: assert property (p_bg_on) else $error("reference dropped");
  property p_bg_off; @(posedge sys_clk) disable iff (!resetn)
    (!rx_section_on && !aux_converter_power && !ref_keep_alive) [*3] |-> !bandgap_reference;
  endproperty
  a_bg_off: assert property (p_bg_off) else $error("reference stuck on");
  // no new sync in the eight cycles after a word's sync
  property p_bb_word; @(posedge link_clk) disable iff (!resetn)
    bb_fs |=> !bb_fs [*8]; endproperty
  a_bb_word: assert property (p_bb_word) else $error("baseband word cut short");
  property p_aux_word; @(posedge link_clk) disable iff (!resetn)
    aux_fs |=> !aux_fs [*8]; endproperty
  a_aux_word: assert property (p_aux_word) else $error("aux word cut short");
  property p_rst; @(posedge sys_clk) disable iff (!resetn)
    $rose(resetn) |-> !aux_converter_power && aux_converter_word == '0; endproperty
  a_rst: assert property (p_rst) else $error("aux state not cleared");
  c_mode2: cover property (@(posedge sys_clk) rx_cut_two_fifths);
  c_bb: cover property (@(posedge link_clk) bb_fs);
  c_aux: cover property (@(posedge link_clk) aux_fs);
endmodule // dpsr_top_checker

bind dpsr_top dpsr_top_checker chk_u (.*);

// ### tb/dpsr_dsp_model.sv
// slave port: sends frames, collects words
module dpsr_dsp_model (
  input  wire logic link_clk,
  input  wire logic fs,
  input  wire logic dev_data,
  output logic      host_fs,
  output logic      sdi
);
  timeunit 1ns;
  timeprecision 100ps;
  dpsr_pkg::dpsr_frame_t got;   // last full word
  dpsr_pkg::dpsr_frame_t prev;  // word before it
  dpsr_pkg::dpsr_frame_t sh;    // shift in progress
  int                    cnt = 0;
  logic [4:0]            n = 5'h0;
  initial
  begin
    host_fs = 1'h0;
    sdi     = 1'h0;
  end
  // sync rides with bit 15, then the other fifteen bits msb first
  task automatic send(input dpsr_pkg::dpsr_frame_t w);
    for (int i = 15; i >= 0; i--)
    begin
      @(posedge link_clk);
      host_fs <= (i == 15);
      sdi     <= w[i];
    end
    @(posedge link_clk);
    host_fs <= 1'h0;
    sdi     <= ~w[0]; // idle line never repeats the last bit
  endtask
  // capture: sync marks the first bit
  always @(posedge link_clk)
  begin
    if (fs)
    begin
      sh <= {15'h0, dev_data};
      n  <= 5'h1;
    end
    else if (n != 5'h0)
    begin
      sh <= {sh[14:0], dev_data};
      n  <= (n == 5'hF) ? 5'h0 : n + 5'h1;
      if (n == 5'hF)
      begin
        prev <= got;
        got  <= {sh[14:0], dev_data};
        cnt  <= cnt + 1;
      end
    end
  end
endmodule // dpsr_dsp_model

// ### tb/dpsr_top_tb.sv
module dpsr_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import dpsr_pkg::*;
  logic sys_clk = 1'h0, link_clk = 1'h0, resetn = 1'h0, receive_enable = 1'h0;
  logic bb_host_fs, bb_sdi, bb_fs, bb_serial_out, aux_host_fs, aux_sdi, aux_fs, aux_serial_out;
  logic rx_section_on, rx_cut_third, rx_cut_two_fifths, ref_keep_alive, ref_output_use;
  logic bandgap_reference, aux_converter_power;
  dpsr_sample_t i_sample = 15'h0, q_sample = 15'h0;
  dpsr_data_t   aux_converter_word;
  int           error_cnt = 0, total_checks = 0;
  always #2.5 sys_clk = ~sys_clk;
  // rises off the master clock's rising edges
  always #40 link_clk = ~link_clk;
  dpsr_top #(.RX_START_CYCLES(4)) dut_u (.*);
  dpsr_dsp_model bbm (.link_clk, .fs(bb_fs), .dev_data(bb_serial_out), .host_fs(bb_host_fs),
    .sdi(bb_sdi));
  dpsr_dsp_model axm (.link_clk, .fs(aux_fs), .dev_data(aux_serial_out),
    .host_fs(aux_host_fs), .sdi(aux_sdi));
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // frame, then time to cross
  task automatic wr(input logic p, input dpsr_addr_t a, input dpsr_data_t d);
    if (p)
      axm.send({d, a});
    else
      bbm.send({d, a});
    repeat (2) @(posedge link_clk);
  endtask
  // pointer write, junk upper bits
  task automatic rd(input logic p, input dpsr_addr_t a, input dpsr_data_t exp);
    int c0;
    c0 = p ? axm.cnt : bbm.cnt;
    wr(p, p ? 6'h09 : 6'h0A, {4'($urandom), a});
    for (int i = 0; i < 60 && (p ? axm.cnt : bbm.cnt) == c0; i++) @(posedge link_clk);
    @(posedge link_clk);
    chk(p ? axm.got : bbm.got, {exp, a});
  endtask
  initial
  begin
    repeat (80000) @(posedge sys_clk);
    error_cnt++;
    summarize();
  end
  initial
  begin
    int         c0;
    dpsr_data_t d;
    c0 = $urandom(32'h6349);
    repeat (10) @(posedge sys_clk);
    repeat (2) @(posedge link_clk);
    @(posedge sys_clk);
    resetn <= 1'h1;
    repeat (4) @(posedge link_clk);
    chk({rx_section_on, bandgap_reference, aux_converter_power, aux_converter_word}, 0);
    $display("reset test done");
    // every power code, written and read back on alternating ports
    for (int c = 0; c < 4; c++)
    begin
      wr(c[0], 6'h14, 10'(c) << 3);
      chk({rx_cut_two_fifths, rx_cut_third}, (c == 1) ? 1 : (c == 2) ? 2 : 0);
      rd(c[0], 6'h14, 10'(c) << 3);
    end
    $display("power test done");
    for (int c = 0; c < 4; c++)
    begin
      @(posedge sys_clk);
      receive_enable <= c[0];
      wr(1'h0, 6'h14, 10'(c[1]) << 6);
      chk(rx_section_on, c != 0);
    end
    @(posedge sys_clk);
    receive_enable <= 1'h0;
    wr(1'h0, 6'h14, 10'h000);
    $display("enable test done");
    d = 10'($urandom);
    wr(1'h1, 6'h0C, d);
    chk(aux_converter_word, d);
    wr(1'h0, 6'h0B, ~d);
    chk(aux_converter_word, d);
    wr(1'h1, 6'h12, 10'h3FF);
    chk(aux_converter_power, 1);
    rd(1'h1, 6'h12, 10'h004);
    wr(1'h0, 6'h15, 10'h3EF);
    chk({ref_keep_alive, ref_output_use}, 3);
    rd(1'h0, 6'h15, 10'h00C);
    wr(1'h1, 6'h13, 10'h001);
    chk({aux_converter_power, aux_converter_word}, 0);
    chk(bandgap_reference, 1);
    rd(1'h1, 6'h13, 10'h000);
    $display("register test done");
    // stream on each port in turn
    for (int p = 0; p < 2; p++)
    begin
      @(posedge link_clk);
      i_sample <= 15'($urandom);
      q_sample <= 15'($urandom);
      wr(1'(p), 6'h15, 10'(p) << 4);
      c0 = p ? axm.cnt : bbm.cnt;
      @(posedge sys_clk);
      receive_enable <= 1'h1;
      for (int i = 0; i < 400 && (p ? axm.cnt : bbm.cnt) < c0 + 2; i++) @(posedge link_clk);
      chk(p ? axm.prev : bbm.prev, {i_sample, 1'h0});
      chk(p ? axm.got : bbm.got, {q_sample, 1'h1});
      @(posedge sys_clk);
      receive_enable <= 1'h0;
      repeat (100) @(posedge link_clk);
    end
    $display("stream test done");
    summarize();
  end
endmodule // dpsr_top_tb
